// ### sptc_defines.vh
`ifndef SPTC_DEFINES_VH
`define SPTC_DEFINES_VH
// register byte offsets
`define SPTC_CTRL_OFF    12'h000
`define SPTC_STATUS_OFF  12'h004
`define SPTC_TXDATA_OFF  12'h008
`define SPTC_RXDATA_OFF  12'h00C
`define SPTC_BAUD_OFF    12'h010
// control register fields
`define SPTC_TX_ON       0
`define SPTC_RX_ON       1
`define SPTC_RX_STANDBY  2
`define SPTC_BREAK_QUEUE 3
`define SPTC_LOOPBACK    4
`define SPTC_SINGLE_SRC  5
`define SPTC_LINE_DIR    6
`define SPTC_LONG_BREAK  7
`define SPTC_WAKE_SEL    8
`define SPTC_CTRL_W      9
// status register fields
`define SPTC_ST_TX_FULL  0
`define SPTC_ST_TX_BUSY  1
`define SPTC_ST_RX_FULL  2
`define SPTC_ST_TX_OWN   3
`define SPTC_ST_RX_OWN   4
`define SPTC_ST_IDLE_PND 5
`define SPTC_ST_BRK_PND  6
`define SPTC_ST_W        7
// reset values
`define SPTC_CTRL_RST    9'h000
`define SPTC_BAUD_RST    16'h0057
// character lengths in bit times
`define SPTC_FRAME_BITS  4'hA
`define SPTC_BREAK_BITS  4'hA
`define SPTC_LBREAK_BITS 4'hD
`define SPTC_IDLE_BITS   4'hA
`endif

// ### sptc_peer.sv
`timescale 1ns/1ps
module sptc_peer #(
  parameter BT = 4
) (
  input  wire pclk,
  input  wire line,
  output reg  rxd
);
  int run;
  int last_run;
  int n_runs;
  initial begin
    rxd = 1'b1;
    run = 0;
    last_run = 0;
    n_runs = 0;
  end
  // length of the last low stretch seen on the line
  always @(posedge pclk) begin
    if (!line) run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      n_runs <= n_runs + 1; // count of finished low stretches
      run <= 0;
    end
  end
  // one character: start, 8 bits lsb first, stop
  task send(input [7:0] b);
    int k;
    for (k = 0; k < 10; k++) begin
      rxd <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[k-1];
      repeat (BT) @(posedge pclk);
    end
  endtask
endmodule // sptc_peer

// ### sptc_props.sv
`timescale 1ns/1ps
module sptc_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        txd_i,
  input wire        txd_o,
  input wire        txd_oe,
  input wire        tx_pin_own,
  input wire        rxd_i,
  input wire        rx_pin_own
);
  reg  [8:0] c_q;
  wire       acc = psel & penable;
  // control bits as last written over the bus
  always @(posedge pclk or negedge presetn)
    if (!presetn) c_q <= 9'h000;
    else if (acc && pwrite && paddr == 12'h000) c_q <= pwdata[8:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_rx_own_map: assert property (rx_pin_own == (c_q[1] & ~c_q[4]))
    else $error("receive pin owner wrong");
  a_tx_own_on: assert property (c_q[0] |-> tx_pin_own)
    else $error("transmit pin not owned");
  a_tx_drive_on: assert property (c_q[0] && !c_q[4] |-> txd_oe)
    else $error("transmit pin not driven");
  a_single_in: assert property (c_q[4] && c_q[5] && !c_q[6] |-> !txd_oe)
    else $error("single wire pin driven as input");
  a_single_out: assert property (c_q[0] && c_q[5] && c_q[4] && c_q[6] |-> txd_oe)
    else $error("single wire pin not driven");
  a_hold_low: assert property (!txd_o |-> tx_pin_own && (txd_oe || c_q[4]))
    else $error("low line without ownership");
  a_owner_drop: assert property ($fell(tx_pin_own) |-> !c_q[0])
    else $error("pin released while enabled");
  a_unmapped_err: assert property (acc && paddr > 12'h010 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 12'h010
    |-> pready && !pslverr) else $error("mapped access refused");
  c_break: cover property (c_q[3] && !txd_o);
  c_single: cover property (c_q[4] && c_q[5] && c_q[6] && txd_oe);
  c_refuse: cover property (acc && pslverr);
endmodule // sptc_props
bind sptc_serial_ctrl sptc_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .txd_i(txd_i), .txd_o(txd_o), .txd_oe(txd_oe),
  .tx_pin_own(tx_pin_own), .rxd_i(rxd_i), .rx_pin_own(rx_pin_own));

// ### sptc_serial_ctrl.v
// Summary of operation
// RULE1: transmitter runs only while tx_on is 1, and then drives the transmit pin; the code also sends a break queued while tx_on is 0.
// RULE2: with loopback_sel and single_line_src set, line_direction picks the pin direction.
// RULE3: single-wire mode: line_direction 0 makes the pin input, 1 makes it output.
// RULE4: tx_on written 0 then 1 during traffic queues one idle character.
// RULE5: after tx_on clears, pin stays driven until data, idle and break finish.
// RULE6: rx_on switches the receiver; when off the receive pin returns to gpio.
// RULE7: loopback_sel 1 returns the receive pin to gpio even with rx_on set.
// RULE8: writing 1 to rx_standby puts the receiver in standby awaiting wakeup.
// RULE9: wakeup is idle line when wake select 0, else character msb of 1.
// RULE10: on the selected wakeup condition hardware clears rx_standby.
// RULE11: after standby clears, following characters are received normally.
// RULE12: writing break_queue 1 then 0 inserts one break into the transmit stream.
// RULE13: while break_queue stays 1 further all-zero breaks of 10 or 13 bits queue.
// RULE14: a second break may be queued before software clears break_queue.
`timescale 1ns/1ps
`include "sptc_defines.vh"
module sptc_serial_ctrl #(
  parameter BAUD_W = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        txd_i,
  output reg         txd_o,
  output wire        txd_oe,
  output wire        tx_pin_own,
  input  wire        rxd_i,
  output wire        rx_pin_own
);
  // tx states
  localparam [3:0] TS_IDLE = 4'b0001;
  localparam [3:0] TS_DATA = 4'b0010;
  localparam [3:0] TS_FILL = 4'b0100;
  localparam [3:0] TS_BRK  = 4'b1000;
  // rx states
  localparam [1:0] RS_IDLE = 2'b01;
  localparam [1:0] RS_BITS = 2'b10;

  reg  [`SPTC_CTRL_W-1:0] ctrl_q;
  reg  [BAUD_W-1:0]       baud_q;
  reg  [7:0]              txbuf_q;
  reg                     tx_full_q;
  reg  [7:0]              rxbuf_q;
  reg                     rx_full_q;
  reg                     idle_pnd_q;
  reg                     brk_pnd_q;
  reg  [3:0]              tx_st_q;
  reg  [9:0]              tx_sh_q;
  reg  [3:0]              tx_cnt_q;
  reg  [BAUD_W-1:0]       tick_cnt_q;
  reg  [1:0]              rx_st_q;
  reg  [BAUD_W-1:0]       rx_cnt_q;
  reg  [3:0]              rx_bit_q;
  reg  [7:0]              rx_sh_q;
  reg  [3:0]              idle_cnt_q;
  wire [1:0]              pin_filt;
  reg                     rx_line_q;
  wire [1:0]              pin_in;
  wire                    wr;
  wire                    rd;
  wire                    mapped;
  wire                    ctrl_wr;
  wire                    tick;
  wire                    tx_busy;
  wire                    single_wire;
  wire                    rx_src;
  wire                    rx_tick;
  wire                    rx_done;
  wire                    rx_frame_ok;
  wire                    idle_seen;
  wire                    wake_hit;
  wire                    deliver;
  wire                    brk_done;
  wire                    tx_start;
  wire [3:0]              brk_len;

  // apb decode, zero wait states
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign mapped  = (paddr == `SPTC_CTRL_OFF) | (paddr == `SPTC_STATUS_OFF) |
                   (paddr == `SPTC_TXDATA_OFF) | (paddr == `SPTC_RXDATA_OFF) |
                   (paddr == `SPTC_BAUD_OFF);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign ctrl_wr = wr & (paddr == `SPTC_CTRL_OFF);

  // pin input synchronisers, a change counts once stages two and three agree
  assign pin_in = {rxd_i, txd_i};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      reg [2:0] stg_q;
      reg       flt_q;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stg_q <= 3'b111;
          flt_q <= 1'b1;
        end else begin
          stg_q <= {stg_q[1:0], pin_in[gi]};
          if (stg_q[1] == stg_q[2]) begin
            flt_q <= stg_q[2];
          end
        end
      end
      assign pin_filt[gi] = flt_q;
    end
  endgenerate

  // bit time tick for transmitter and idle counting
  assign tick = (tick_cnt_q == {BAUD_W{1'b0}});
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= {BAUD_W{1'b0}};
    end else if (tick) begin
      tick_cnt_q <= baud_q;
    end else begin
      tick_cnt_q <= tick_cnt_q - {{(BAUD_W-1){1'b0}}, 1'b1};
    end
  end

  // control, baud and transmit buffer registers
  assign tx_busy     = (tx_st_q != TS_IDLE);
  assign tx_start    = tick & (tx_st_q == TS_IDLE) & ~brk_pnd_q & ~idle_pnd_q & tx_full_q;
  assign single_wire = ctrl_q[`SPTC_LOOPBACK] & ctrl_q[`SPTC_SINGLE_SRC];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= `SPTC_CTRL_RST;
      baud_q    <= `SPTC_BAUD_RST;
      txbuf_q   <= 8'h00;
      tx_full_q <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= pwdata[`SPTC_CTRL_W-1:0];
        // a standby set written now wins over a wakeup clear in the same cycle
        if (wake_hit & ~pwdata[`SPTC_RX_STANDBY]) begin
          ctrl_q[`SPTC_RX_STANDBY] <= 1'b0;
        end
      end else if (wake_hit) begin
        ctrl_q[`SPTC_RX_STANDBY] <= 1'b0; // RULE10
      end
      if (wr & (paddr == `SPTC_BAUD_OFF)) begin
        baud_q <= pwdata[BAUD_W-1:0];
      end
      // data is accepted only while the transmitter is on
      if (wr & (paddr == `SPTC_TXDATA_OFF) & ctrl_q[`SPTC_TX_ON]) begin
        txbuf_q   <= pwdata[7:0];
        tx_full_q <= 1'b1; // RULE1
      end else if (tx_start) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  // queued idle and queued break requests
  assign brk_len  = ctrl_q[`SPTC_LONG_BREAK] ? `SPTC_LBREAK_BITS : `SPTC_BREAK_BITS;
  assign brk_done = tick & (tx_st_q == TS_BRK) & (tx_cnt_q == 4'h1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_pnd_q <= 1'b0;
      brk_pnd_q  <= 1'b0;
    end else begin
      if (ctrl_wr & ~ctrl_q[`SPTC_TX_ON] & pwdata[`SPTC_TX_ON] & tx_busy) begin
        idle_pnd_q <= 1'b1; // RULE4
      end else if (tick & (tx_st_q == TS_IDLE) & ~brk_pnd_q) begin
        idle_pnd_q <= 1'b0;
      end
      if (ctrl_wr & ~ctrl_q[`SPTC_BREAK_QUEUE] & pwdata[`SPTC_BREAK_QUEUE]) begin
        brk_pnd_q <= 1'b1; // RULE12
      end else if (brk_done & ctrl_q[`SPTC_BREAK_QUEUE] & ctrl_q[`SPTC_TX_ON]) begin
        brk_pnd_q <= 1'b1; // RULE13 RULE14
      end else if (tick & (tx_st_q == TS_IDLE)) begin
        brk_pnd_q <= 1'b0;
      end
    end
  end

  // transmit sequencer: break first, then idle, then data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q  <= TS_IDLE;
      tx_sh_q  <= 10'h3FF;
      tx_cnt_q <= 4'h0;
      txd_o    <= 1'b1;
    end else if (tick) begin
      case (tx_st_q)
        TS_IDLE: begin
          if (brk_pnd_q) begin
            tx_st_q  <= TS_BRK;
            tx_cnt_q <= brk_len; // RULE13
            txd_o    <= 1'b0;
          end else if (idle_pnd_q) begin
            tx_st_q  <= TS_FILL;
            tx_cnt_q <= `SPTC_IDLE_BITS;
            txd_o    <= 1'b1;
          end else if (tx_full_q) begin
            tx_st_q  <= TS_DATA;
            tx_cnt_q <= `SPTC_FRAME_BITS;
            tx_sh_q  <= {1'b1, 1'b1, txbuf_q};
            txd_o    <= 1'b0;
          end else begin
            txd_o <= 1'b1;
          end
        end
        TS_DATA: begin
          txd_o    <= tx_sh_q[0];
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_cnt_q <= tx_cnt_q - 4'h1;
          if (tx_cnt_q == 4'h1) begin
            tx_st_q <= TS_IDLE;
            txd_o   <= 1'b1;
          end
        end
        TS_FILL, TS_BRK: begin
          tx_cnt_q <= tx_cnt_q - 4'h1;
          if (tx_cnt_q == 4'h1) begin
            tx_st_q <= TS_IDLE;
            txd_o   <= 1'b1;
          end
        end
        default: begin
          tx_st_q <= TS_IDLE;
          txd_o   <= 1'b1;
        end
      endcase
    end
  end

  // pin ownership and direction
  assign tx_pin_own = ctrl_q[`SPTC_TX_ON] | tx_busy | tx_full_q | idle_pnd_q | brk_pnd_q; // RULE1 RULE5
  assign txd_oe     = tx_pin_own & ~(single_wire & ~ctrl_q[`SPTC_LINE_DIR]); // RULE2 RULE3
  assign rx_pin_own = ctrl_q[`SPTC_RX_ON] & ~ctrl_q[`SPTC_LOOPBACK]; // RULE6 RULE7

  // receiver source: pin, internal loop, or the single shared line
  assign rx_src = ~ctrl_q[`SPTC_LOOPBACK] ? pin_filt[1] :
                  (ctrl_q[`SPTC_SINGLE_SRC] ? pin_filt[0] : txd_o); // RULE2
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_line_q <= 1'b1;
    end else begin
      rx_line_q <= rx_src;
    end
  end

  // receiver: start detect, mid-bit sampling, stop check
  assign rx_tick     = (rx_st_q == RS_BITS) & (rx_cnt_q == {BAUD_W{1'b0}});
  assign rx_done     = rx_tick & (rx_bit_q == 4'h9);
  assign rx_frame_ok = rx_done & rx_line_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q  <= RS_IDLE;
      rx_cnt_q <= {BAUD_W{1'b0}};
      rx_bit_q <= 4'h0;
      rx_sh_q  <= 8'h00;
    end else begin
      case (rx_st_q)
        RS_IDLE: begin
          if (ctrl_q[`SPTC_RX_ON] & ~rx_line_q) begin // RULE6
            rx_st_q  <= RS_BITS;
            rx_cnt_q <= {1'b0, baud_q[BAUD_W-1:1]};
            rx_bit_q <= 4'h0;
          end
        end
        RS_BITS: begin
          if (!ctrl_q[`SPTC_RX_ON]) begin
            rx_st_q <= RS_IDLE;
          end else if (rx_tick) begin
            rx_cnt_q <= baud_q;
            rx_bit_q <= rx_bit_q + 4'h1;
            if ((rx_bit_q == 4'h0) & rx_line_q) begin
              rx_st_q <= RS_IDLE; // false start
            end else if (rx_bit_q == 4'h9) begin
              rx_st_q <= RS_IDLE;
            end else if (rx_bit_q != 4'h0) begin
              rx_sh_q <= {rx_line_q, rx_sh_q[7:1]};
            end
          end else begin
            rx_cnt_q <= rx_cnt_q - {{(BAUD_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          rx_st_q <= RS_IDLE;
        end
      endcase
    end
  end

  // idle line detection counts whole bit times of marking level
  assign idle_seen = tick & (rx_st_q == RS_IDLE) & rx_line_q & (idle_cnt_q == `SPTC_IDLE_BITS - 4'h1);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= 4'h0;
    end else if ((rx_st_q != RS_IDLE) | ~rx_line_q) begin
      idle_cnt_q <= 4'h0;
    end else if (tick & (idle_cnt_q != `SPTC_IDLE_BITS)) begin
      idle_cnt_q <= idle_cnt_q + 4'h1;
    end
  end

  // wakeup and delivery of received characters
  assign wake_hit = ctrl_q[`SPTC_RX_STANDBY] & ctrl_q[`SPTC_RX_ON] &
                    (ctrl_q[`SPTC_WAKE_SEL] ? (rx_frame_ok & rx_sh_q[7]) : idle_seen); // RULE8 RULE9
  assign deliver  = rx_frame_ok & (~ctrl_q[`SPTC_RX_STANDBY] | wake_hit); // RULE11
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_q   <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      if (deliver) begin
        rxbuf_q   <= rx_sh_q;
        rx_full_q <= 1'b1; // new data wins over a read clear
      end else if (rd & (paddr == `SPTC_RXDATA_OFF)) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // read data mux
  always @* begin
    prdata = 32'h00000000;
    if (rd) begin
      case (paddr)
        `SPTC_CTRL_OFF:   prdata[`SPTC_CTRL_W-1:0] = ctrl_q;
        `SPTC_STATUS_OFF: prdata[`SPTC_ST_W-1:0] = {brk_pnd_q, idle_pnd_q, rx_pin_own,
                                                    tx_pin_own, rx_full_q, tx_busy, tx_full_q};
        `SPTC_RXDATA_OFF: prdata[7:0] = rxbuf_q;
        `SPTC_BAUD_OFF:   prdata[BAUD_W-1:0] = baud_q;
        default:          prdata = 32'h00000000;
      endcase
    end
  end
endmodule // sptc_serial_ctrl

// ### tb.sv
`timescale 1ns/1ps
module tb;
  localparam BT = 4;
  reg         pclk, presetn, psel, penable, pwrite, rerr;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rv;
  wire [31:0] prdata;
  wire        pready, pslverr, txd_o, txd_oe, tx_pin_own, rx_pin_own, rxd_i;
  wire        txd_i = txd_oe ? txd_o : 1'b1;
  int         n_errors, total_checks, i, k;
  // per entry: expected {tx_pin_own, txd_oe, rx_pin_own} in bits 11:9, control word in 8:0
  localparam [71:0] TAB = {12'h000, 12'hC71, 12'h831, 12'hC01, 12'h012, 12'h202};
  sptc_serial_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd_i(txd_i), .txd_o(txd_o), .txd_oe(txd_oe),
    .tx_pin_own(tx_pin_own), .rxd_i(rxd_i), .rx_pin_own(rx_pin_own));
  sptc_peer #(.BT(BT)) u_peer (.pclk(pclk), .line(txd_i), .rxd(rxd_i));
  task chk(input [31:0] g, input [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one bus transfer, read data taken at the ready edge
  task xfer(input w, input [11:0] a, input [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wdone;
    rv = 32'h2;
    for (k = 0; k < 300 && (rv & 32'h62) != 0; k++) xfer(0, 12'h004, 0);
    chk(rv & 32'h62, 0);
  endtask
  task test_done;
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    test_done;
  end
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    n_errors = 0; total_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(0, 12'h000, 0); chk(rv, 0);
    xfer(0, 12'h010, 0); chk(rv, 32'h57);
    xfer(0, 12'h020, 0);
    chk(rv, 0);
    chk(rerr, 1);
    xfer(1, 12'h010, BT - 1);
    // pin ownership and direction per control setting
    for (i = 0; i < 6; i++) begin
      xfer(1, 12'h000, TAB[i*12 +: 9]);
      chk({tx_pin_own, txd_oe, rx_pin_own}, TAB[i*12+9 +: 3]);
    end
    // disable during a frame keeps the pin until the stop bit ends
    xfer(1, 12'h000, 1); xfer(1, 12'h008, 0); xfer(1, 12'h000, 0);
    chk({tx_pin_own, txd_oe}, 3);
    for (i = 0; i < 300 && tx_pin_own; i++) @(posedge pclk);
    chk(tx_pin_own, 0);
    chk(u_peer.last_run, 9 * BT);
    xfer(1, 12'h000, 1); xfer(1, 12'h008, 32'h55); xfer(1, 12'h000, 0); xfer(1, 12'h000, 1);
    xfer(0, 12'h004, 0); chk(rv[5], 1);
    wdone;
    for (i = 0; i < 2; i++) begin
      xfer(1, 12'h000, 9 | (i << 7)); xfer(1, 12'h000, 1 | (i << 7));
      wdone;
      chk(u_peer.last_run, (i ? 13 : 10) * BT);
    end
    // break_queue held across a break end: two breaks, each of normal length
    i = u_peer.n_runs;
    xfer(1, 12'h000, 9);
    repeat (60) @(posedge pclk);
    xfer(1, 12'h000, 1);
    wdone;
    chk(u_peer.last_run, 10 * BT);
    chk(u_peer.n_runs - i, 2);
    // address mark wakeup, then normal reception
    xfer(1, 12'h000, 32'h106);
    u_peer.send(8'h15); repeat (8) @(posedge pclk);
    xfer(0, 12'h004, 0); chk(rv[2], 0);
    xfer(0, 12'h000, 0); chk(rv[2], 1);
    u_peer.send(8'h95); repeat (8) @(posedge pclk);
    xfer(0, 12'h000, 0); chk(rv[2], 0);
    xfer(0, 12'h00C, 0); chk(rv, 32'h95);
    u_peer.send(8'h2A); repeat (8) @(posedge pclk);
    xfer(0, 12'h00C, 0); chk(rv, 32'h2A);
    xfer(1, 12'h000, 32'h006);
    xfer(0, 12'h000, 0);
    chk(rv[2], 1);
    repeat (12 * BT + 8) @(posedge pclk);
    xfer(0, 12'h000, 0); chk(rv[2], 0);
    test_done;
  end
endmodule // tb
